// ==== common/adc_pkg.sv ====
// Shared constants and types of the converter control block.
package adc_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_PORT_DATA    = 8'h05;
  localparam logic [7:0]  IDX_IRQ_CONTROL  = 8'h0B;
  localparam logic [7:0]  IDX_PERIPH_FLAGS = 8'h0C;
  localparam logic [7:0]  IDX_RESULT       = 8'h1E;
  localparam logic [7:0]  IDX_CONV_CONTROL = 8'h1F;
  localparam logic [7:0]  IDX_PORT_DIR     = 8'h85;
  localparam logic [7:0]  IDX_PERIPH_EN    = 8'h8C;
  localparam logic [7:0]  IDX_PIN_CONFIG   = 8'h9F;
  localparam logic [11:0] ADDR_PORT_DATA    = {2'h0, IDX_PORT_DATA, 2'h0};
  localparam logic [11:0] ADDR_IRQ_CONTROL  = {2'h0, IDX_IRQ_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_PERIPH_FLAGS = {2'h0, IDX_PERIPH_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_RESULT       = {2'h0, IDX_RESULT, 2'h0};
  localparam logic [11:0] ADDR_CONV_CONTROL = {2'h0, IDX_CONV_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_PORT_DIR     = {2'h0, IDX_PORT_DIR, 2'h0};
  localparam logic [11:0] ADDR_PERIPH_EN    = {2'h0, IDX_PERIPH_EN, 2'h0};
  localparam logic [11:0] ADDR_PIN_CONFIG   = {2'h0, IDX_PIN_CONFIG, 2'h0};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL_ON_BIT   = 0;
  localparam int unsigned CTL_GO_BIT   = 2;
  localparam int unsigned CTL_CH_LSB   = 3;
  localparam int unsigned CTL_CS_LSB   = 6;
  localparam int unsigned DONE_FLAG_BIT = 6;
  localparam int unsigned DONE_IEN_BIT  = 6;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_CLOCK_SEL = 2'h0;
  localparam logic [2:0] RST_CHANNEL   = 3'h0;
  localparam logic [5:0] RST_PORT_DIR  = 6'h3F;
  localparam logic [5:0] RST_PORT_OUT  = 6'h00;
  localparam logic [2:0] RST_PIN_CFG   = 3'h0;
  localparam logic [7:0] RST_IRQ_CTRL  = 8'h00;

  // ----------------------------------------------------------------
  // Conversion timing, in oscillator periods and half conversion clocks
  // ----------------------------------------------------------------
  localparam logic [3:0] CCP_SPECIAL_EVENT = 4'hB;
  localparam logic [1:0] CS_RC_SOURCE      = 2'h3;
  localparam int unsigned TAD_OSC_A = 2;
  localparam int unsigned TAD_OSC_B = 8;
  localparam int unsigned TAD_OSC_C = 32;
  localparam logic [4:0] HALF_TAD_A = 5'(TAD_OSC_A / 2);
  localparam logic [4:0] HALF_TAD_B = 5'(TAD_OSC_B / 2);
  localparam logic [4:0] HALF_TAD_C = 5'(TAD_OSC_C / 2);
  localparam logic [4:0] CONV_LAST_HALF = 5'h12;
  localparam logic [4:0] LAST_DECISION  = 5'h0F;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_t;

endpackage

// ==== core/adc_conversion_control.sv ====
// Converter control: registers, pin logic, trigger and 8-bit sequencer.
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Notes on behaviour
// - A conversion lasts nine and a half conversion-clock periods after start.
// - Clock select 00/01/10 gives 2/8/32 oscillator periods, 11 the RC source.
// - A selected pin driven as output converts its own driven digital level.
// - Port data reads return zero on pins configured as analog.
// - Digitally configured inputs still convert when selected, without accuracy loss.
// - Special event with mode 1011 and converter on sets go and starts.
// - Every special event with mode 1011 clears the sixteen-bit timer count.
// - With converter off the event starts nothing but still clears the timer.
// - Completion stores the result, clears go and sets the complete flag.
// - The result register has no reset and keeps its content.
// ------------------------------------------------------------------
module adc_conversion_control (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  pin_in,
  output logic [5:0]       pin_out,
  output logic [5:0]       pin_oe,
  input  wire logic        cmp_above,
  input  wire logic        rc_osc,
  input  wire logic [3:0]  capture_compare_mode_field,
  input  wire logic        special_event,
  output logic             timer_clear,
  output logic [2:0]       channel_select_field,
  output logic [7:0]       trial_code,
  output logic             converter_on_bit
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  adc_pkg::conv_state_t state_ff, nxt_state;
  logic [1:0]  clock_select_field_ff;
  logic [2:0]  channel_ff, pin_cfg_ff, sel_pin, bitpos;
  logic [4:0]  half_cnt_ff, nxt_half_cnt;
  logic [5:0]  dir_ff, port_ff, pin_s1_ff, pin_s2_ff, analog_mask;
  logic [7:0]  irq_ctrl_ff, result_ff, sar_ff, nxt_sar, rd_byte;
  logic [31:0] prdata_ff;
  logic        on_ff, done_flag_ff, done_ien_ff, cmp_s1_ff, cmp_s2_ff, pslverr_ff;
  logic        timer_clear_ff, setup, wr_en, wr_ctrl, wr_flags, known_addr;
  logic        sel_valid, sel_is_output, decision, decide, converting, event_hit;
  logic        trig_start, sw_start, start, abort, done, half_tick, hlp_result_seen_ff;

  // ----------------------------------------------------------------
  // Decoding functions
  // ----------------------------------------------------------------
  // Analog pins, bit order RA5..RA0; RA4 is always digital.
  function automatic logic [5:0] analog_pins(input logic [2:0] cfg);
    analog_pins = cfg[2] ? (cfg[1] ? 6'h00 : 6'h0B) : 6'h2F;
  endfunction

  function automatic logic [2:0] channel_pin(input logic [2:0] ch);
    channel_pin = (ch == 3'h4) ? 3'h5 : ch;
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setup    = psel && !penable;
  assign wr_en    = psel && penable && pwrite;
  assign wr_ctrl  = wr_en && (paddr == adc_pkg::ADDR_CONV_CONTROL);
  assign wr_flags = wr_en && (paddr == adc_pkg::ADDR_PERIPH_FLAGS);
  assign pready   = 1'b1;
  assign prdata   = prdata_ff;
  assign pslverr  = pslverr_ff;

  assign known_addr = (paddr == adc_pkg::ADDR_PORT_DATA) ||
                      (paddr == adc_pkg::ADDR_IRQ_CONTROL) ||
                      (paddr == adc_pkg::ADDR_PERIPH_FLAGS) ||
                      (paddr == adc_pkg::ADDR_RESULT) ||
                      (paddr == adc_pkg::ADDR_CONV_CONTROL) ||
                      (paddr == adc_pkg::ADDR_PORT_DIR) ||
                      (paddr == adc_pkg::ADDR_PERIPH_EN) ||
                      (paddr == adc_pkg::ADDR_PIN_CONFIG);

  assign analog_mask = analog_pins(pin_cfg_ff);
  assign rd_byte =
    (paddr == adc_pkg::ADDR_PORT_DATA)    ? {2'h0, pin_s2_ff & ~analog_mask} :
    (paddr == adc_pkg::ADDR_IRQ_CONTROL)  ? irq_ctrl_ff :
    (paddr == adc_pkg::ADDR_PERIPH_FLAGS) ? {1'b0, done_flag_ff, 6'h00} :
    (paddr == adc_pkg::ADDR_RESULT)       ? result_ff :
    (paddr == adc_pkg::ADDR_CONV_CONTROL) ? {clock_select_field_ff, channel_ff,
                                             converting, 1'b0, on_ff} :
    (paddr == adc_pkg::ADDR_PORT_DIR)     ? {2'h0, dir_ff} :
    (paddr == adc_pkg::ADDR_PERIPH_EN)    ? {1'b0, done_ien_ff, 6'h00} :
    (paddr == adc_pkg::ADDR_PIN_CONFIG)   ? {5'h00, pin_cfg_ff} :
                                            8'h00;

  // Read data is captured in the setup cycle so the access phase needs no wait.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (setup)
    begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : {24'h000000, rd_byte};
      pslverr_ff <= !known_addr;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_select_field_ff <= adc_pkg::RST_CLOCK_SEL;
      channel_ff            <= adc_pkg::RST_CHANNEL;
      on_ff                 <= 1'b0;
      dir_ff                <= adc_pkg::RST_PORT_DIR;
      port_ff               <= adc_pkg::RST_PORT_OUT;
      pin_cfg_ff            <= adc_pkg::RST_PIN_CFG;
      irq_ctrl_ff           <= adc_pkg::RST_IRQ_CTRL;
      done_ien_ff           <= 1'b0;
    end
    else if (wr_en)
    begin
      if (wr_ctrl)
      begin
        clock_select_field_ff <= pwdata[adc_pkg::CTL_CS_LSB +: 2];
        channel_ff            <= pwdata[adc_pkg::CTL_CH_LSB +: 3];
        on_ff                 <= pwdata[adc_pkg::CTL_ON_BIT];
      end
      if (paddr == adc_pkg::ADDR_PORT_DIR)
        dir_ff <= pwdata[5:0];
      if (paddr == adc_pkg::ADDR_PORT_DATA)
        port_ff <= pwdata[5:0];
      if (paddr == adc_pkg::ADDR_PIN_CONFIG)
        pin_cfg_ff <= pwdata[2:0];
      if (paddr == adc_pkg::ADDR_IRQ_CONTROL)
        irq_ctrl_ff <= pwdata[7:0];
      if (paddr == adc_pkg::ADDR_PERIPH_EN)
        done_ien_ff <= pwdata[adc_pkg::DONE_IEN_BIT];
    end
  end

  // A completion in the same cycle as a software clear keeps the flag set.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_flag_ff <= 1'b0;
    else
      done_flag_ff <= done || (wr_flags ? pwdata[adc_pkg::DONE_FLAG_BIT] : done_flag_ff);
  end

  // ----------------------------------------------------------------
  // Pin and comparator synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_ff <= 6'h00;
      pin_s2_ff <= 6'h00;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end
    else
    begin
      pin_s1_ff <= pin_in;
      pin_s2_ff <= pin_s1_ff;
      cmp_s1_ff <= cmp_above;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  assign pin_out = port_ff;
  assign pin_oe  = ~dir_ff;

  // ----------------------------------------------------------------
  // Start, trigger and stop conditions
  // ----------------------------------------------------------------
  assign converting = (state_ff == adc_pkg::ST_CONV);
  assign event_hit  = special_event &&
                      (capture_compare_mode_field == adc_pkg::CCP_SPECIAL_EVENT);
  assign trig_start = event_hit && on_ff && !converting;
  // Go only counts when the converter was already on before this write.
  assign sw_start   = wr_ctrl && pwdata[adc_pkg::CTL_GO_BIT] && on_ff && !converting;
  assign start      = trig_start || sw_start;
  assign done       = converting && half_tick && (half_cnt_ff == adc_pkg::CONV_LAST_HALF);
  assign abort      = converting && !done && wr_ctrl &&
                      (!pwdata[adc_pkg::CTL_GO_BIT] || !pwdata[adc_pkg::CTL_ON_BIT]);

  assign nxt_state = start ? adc_pkg::ST_CONV :
                     (done || abort) ? adc_pkg::ST_IDLE : state_ff;

  // The timer clear is independent of the converter being on.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_clear_ff <= 1'b0;
    else
      timer_clear_ff <= event_hit;
  end
  assign timer_clear = timer_clear_ff;

  // ----------------------------------------------------------------
  // Conversion clock and sequencer
  // ----------------------------------------------------------------
  adc_tad_gen u_tad_gen (
    .pclk         (pclk),
    .presetn      (presetn),
    .clock_select (clock_select_field_ff),
    .restart      (start),
    .rc_osc       (rc_osc),
    .half_tick    (half_tick)
  );

  // Nineteen half periods: eight decisions on odd counts, result on the last.
  assign nxt_half_cnt = start ? 5'h00 :
                        (converting && half_tick) ? half_cnt_ff + 5'h01 : half_cnt_ff;
  assign decide = converting && half_tick && half_cnt_ff[0] &&
                  (half_cnt_ff <= adc_pkg::LAST_DECISION);
  assign bitpos = 3'h7 - half_cnt_ff[3:1];

  assign sel_pin       = channel_pin(channel_ff);
  assign sel_valid     = (channel_ff <= 3'h4);
  assign sel_is_output = sel_valid && !dir_ff[sel_pin];
  // Digital inputs go through the comparator like any analog pin.
  assign decision = sel_is_output ? port_ff[sel_pin] : cmp_s2_ff;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_sar
      assign nxt_sar[gi] = start ? (gi == 7) :
                           (decide && bitpos == 3'(gi)) ? decision :
                           (decide && {1'b0, bitpos} == 4'(gi + 1)) ? 1'b1 : sar_ff[gi];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff    <= adc_pkg::ST_IDLE;
      sar_ff      <= 8'h00;
      half_cnt_ff <= 5'h00;
    end
    else
    begin
      state_ff    <= nxt_state;
      sar_ff      <= nxt_sar;
      half_cnt_ff <= nxt_half_cnt;
    end
  end

  // No reset here: the result survives every reset.
  always_ff @(posedge pclk)
  begin
    if (done)
      result_ff <= sar_ff;
  end

  assign channel_select_field = channel_ff;
  assign trial_code           = sar_ff;
  assign converter_on_bit     = on_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [5:0] hlp_halves_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hlp_halves_ff <= 6'h00;
    else if (start)
      hlp_halves_ff <= 6'h00;
    else if (converting && half_tick)
      hlp_halves_ff <= hlp_halves_ff + 6'h01;
  end

  // No reset: the hold check starts with the first result and then spans every reset.
  always_ff @(posedge pclk)
  begin
    if (done)
      hlp_result_seen_ff <= 1'b1;
  end

  AST_CONV_LENGTH: assert property (@(posedge pclk) disable iff (!presetn)
    done |-> hlp_halves_ff == 6'h12)
    else $error("Conversion did not take nineteen half periods.");
  AST_FAST_CLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (converting && clock_select_field_ff == 2'h0 && !start) |-> half_tick)
    else $error("Two-period clock select missed a half tick.");
  AST_MID_CLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (half_tick && converting && clock_select_field_ff == 2'h1) |=> !half_tick [*3])
    else $error("Eight-period clock select ticked too early.");
  AST_PORT_ANALOG_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == adc_pkg::ADDR_PORT_DATA)
      |=> (prdata[5:0] & $past(analog_mask)) == 6'h00)
    else $error("Analog pin read as nonzero.");
  AST_TRIGGER_START: assert property (@(posedge pclk) disable iff (!presetn)
    (event_hit && on_ff && !converting) |=> converting && sar_ff == 8'h80)
    else $error("Special event did not start a conversion.");
  AST_TIMER_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    event_hit |=> timer_clear)
    else $error("Special event did not clear the timer.");
  AST_OFF_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    (!on_ff && !converting) |=> !converting)
    else $error("Conversion started with converter off.");
  AST_DONE_EFFECTS: assert property (@(posedge pclk) disable iff (!presetn)
    done |=> !converting && done_flag_ff && result_ff == $past(sar_ff))
    else $error("Completion effects missing.");
  AST_RESULT_HOLD: assert property (@(posedge pclk)
    (hlp_result_seen_ff && !done) |=> $stable(result_ff))
    else $error("Result changed without a completion.");
  AST_MSB_DECIDED_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    (decide && half_cnt_ff == 5'h01) |=> sar_ff[7:6] == {$past(decision), 1'b1})
    else $error("First decision was not the top bit.");

  COV_SW_CONVERSION: cover property (@(posedge pclk) disable iff (!presetn)
    sw_start ##[1:800] done);
  COV_TRIGGER_CONVERSION: cover property (@(posedge pclk) disable iff (!presetn)
    trig_start ##[1:800] done);
  COV_ABORT: cover property (@(posedge pclk) disable iff (!presetn) abort);
  COV_PIN_OUTPUT_CONVERT: cover property (@(posedge pclk) disable iff (!presetn)
    decide && sel_is_output);

endmodule

// ==== core/adc_tad_gen.sv ====
// Half conversion-clock tick generator for the converter sequencer.
`timescale 1ns/10ps
module adc_tad_gen (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] clock_select,
  input  wire logic       restart,
  input  wire logic       rc_osc,
  output logic            half_tick
);

  // ----------------------------------------------------------------
  // Internal RC source, brought into the pclk domain
  // ----------------------------------------------------------------
  logic       rc_s1_ff;
  logic       rc_s2_ff;
  logic       rc_s3_ff;
  logic [4:0] div_ff;
  logic [4:0] nxt_div;
  logic [4:0] half_len;
  logic       div_tick;
  logic       rc_edge;

  // Every RC edge is one half period, so the RC period must exceed four pclk periods.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rc_s1_ff <= 1'b0;
      rc_s2_ff <= 1'b0;
      rc_s3_ff <= 1'b0;
    end
    else
    begin
      rc_s1_ff <= rc_osc;
      rc_s2_ff <= rc_s1_ff;
      rc_s3_ff <= rc_s2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator divider
  // ----------------------------------------------------------------
  assign half_len = (clock_select == 2'h0) ? adc_pkg::HALF_TAD_A :
                    (clock_select == 2'h1) ? adc_pkg::HALF_TAD_B :
                                             adc_pkg::HALF_TAD_C;
  assign div_tick = (div_ff == half_len - 5'h01);
  assign rc_edge  = rc_s2_ff ^ rc_s3_ff;
  assign nxt_div  = (restart || div_tick) ? 5'h00 : div_ff + 5'h01;
  assign half_tick = !restart &&
                     ((clock_select == adc_pkg::CS_RC_SOURCE) ? rc_edge : div_tick);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_ff <= 5'h00;
    else
      div_ff <= nxt_div;
  end

endmodule

// ==== testbench/adc_far_side.sv ====
// Far-side model: port pin levels, held analog input and the internal RC source.
`timescale 1ns/10ps
module adc_far_side (
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [7:0] trial_code,
  input  wire logic [7:0] vin,
  input  wire logic [5:0] ext_pins,
  output logic [5:0]      pin_in,
  output logic            cmp_above,
  output logic            rc_osc
);
  // ------------------------------------------------------------------
  // Pins, comparator and RC source
  // ------------------------------------------------------------------
  // A pin shows the device's level where it drives, else the outside level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_pins);
  // The trial bit is kept while the held input is at or above the trial code.
  assign cmp_above = (vin >= trial_code);
  // Free-running RC source, so each edge spans two microseconds.
  initial
  begin
    rc_osc = 1'b0;
    forever #2000 rc_osc = ~rc_osc;
  end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the converter control block.
`timescale 1ns/10ps
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  pin_in;
  logic [5:0]  pin_out;
  logic [5:0]  pin_oe;
  logic        cmp_above;
  logic        rc_osc;
  logic [3:0]  ccp_mode;
  logic        special_event;
  logic        timer_clear;
  logic [2:0]  chan;
  logic [7:0]  trial;
  logic        on_bit;
  logic [7:0]  vin;
  logic [5:0]  ext_pins;
  logic [31:0] q;
  logic        slv;
  int          pulses;
  int          err_count;
  int          n_checks;
  // Only the RC code keeps the period at or above 1.6 us at this clock; divided codes test timing only.
  logic [1:0]  csv [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
  int          hv [4] = '{4, 4, 16, 0};

  adc_conversion_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .cmp_above(cmp_above), .rc_osc(rc_osc), .capture_compare_mode_field(ccp_mode),
    .special_event(special_event), .timer_clear(timer_clear), .channel_select_field(chan),
    .trial_code(trial), .converter_on_bit(on_bit));
  adc_far_side far (.pin_out(pin_out), .pin_oe(pin_oe), .trial_code(trial), .vin(vin),
    .ext_pins(ext_pins), .pin_in(pin_in), .cmp_above(cmp_above), .rc_osc(rc_osc));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------------
  // Bus, comparison and model tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  // Reference result: most significant bit decided first against the held input.
  function automatic logic [7:0] sar(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 7; b >= 0; b--)
      if (v >= (r | (8'h01 << b)))
        r = r | (8'h01 << b);
    return r;
  endfunction

  task automatic pulse();
    @(posedge pclk);
    ccp_mode <= adc_pkg::CCP_SPECIAL_EVENT;
    special_event <= 1'b1;
    @(posedge pclk);
    special_event <= 1'b0;
    pulses = 0;
    repeat (3)
    begin
      @(posedge pclk);
      pulses += int'(timer_clear === 1'b1);
    end
    chk(32'(pulses), 32'h1);
  endtask

  task automatic conv(input logic [7:0] ctl, input int half, input logic [7:0] e, input bit trig);
    int n;
    apb(1'b1, adc_pkg::ADDR_CONV_CONTROL, ctl);
    repeat (16) @(posedge pclk);
    if (trig)
      pulse();
    else
      apb(1'b1, adc_pkg::ADDR_CONV_CONTROL, ctl | 8'h04);
    n = 0;
    q = 32'h4;
    while (q[2] !== 1'b0 && n < 3000)
    begin
      apb(1'b0, adc_pkg::ADDR_CONV_CONTROL, 8'h00);
      n += 3;
    end
    if (half > 0)
      chk(32'(n + 3 >= 19 * half && n <= 19 * half + 8), 32'h1);
    rdc(adc_pkg::ADDR_RESULT, {24'h0, e});
    rdc(adc_pkg::ADDR_PERIPH_FLAGS, 32'h40);
    apb(1'b1, adc_pkg::ADDR_PERIPH_FLAGS, 8'h00);
    repeat (4 * half + 2) @(posedge pclk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Test sequence and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    repeat (30000) @(posedge pclk);
    err_count++;
    $display("watchdog expired");
    finish_test();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, special_event} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    ccp_mode = 4'h0;
    vin = 8'h5A;
    ext_pins = 6'h00;
    err_count = 0;
    n_checks = 0;
    void'($urandom(79));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(adc_pkg::ADDR_CONV_CONTROL, 32'h0);
    rdc(adc_pkg::ADDR_PORT_DIR, 32'h3F);
    rdc(adc_pkg::ADDR_PERIPH_FLAGS, 32'h0);
    rdc(adc_pkg::ADDR_PIN_CONFIG, 32'h0);
    rdc(12'h000, 32'h0);
    chk({31'h0, slv}, 32'h1);
    apb(1'b1, adc_pkg::ADDR_PERIPH_EN, 8'hFF);
    rdc(adc_pkg::ADDR_PERIPH_EN, 32'h40);
    $display("register test done");
    ext_pins <= 6'($urandom());
    apb(1'b1, adc_pkg::ADDR_PIN_CONFIG, 8'h00);
    rdc(adc_pkg::ADDR_PORT_DATA, {26'h0, ext_pins & 6'h10});
    apb(1'b1, adc_pkg::ADDR_PIN_CONFIG, 8'h04);
    rdc(adc_pkg::ADDR_PORT_DATA, {26'h0, ext_pins & 6'h34});
    apb(1'b1, adc_pkg::ADDR_PIN_CONFIG, 8'h06);
    rdc(adc_pkg::ADDR_PORT_DATA, {26'h0, ext_pins});
    apb(1'b1, adc_pkg::ADDR_CONV_CONTROL, 8'h05);
    rdc(adc_pkg::ADDR_CONV_CONTROL, 32'h01);
    apb(1'b1, adc_pkg::ADDR_PORT_DIR, 8'h3E);
    @(negedge pclk);
    chk({26'h0, pin_oe}, 32'h01);
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, adc_pkg::ADDR_PORT_DATA, 8'(k));
      @(negedge pclk);
      chk({26'h0, pin_out}, 32'(k));
      conv(8'h01, 1, k ? 8'hFF : 8'h00, 1'b0);
    end
    apb(1'b1, adc_pkg::ADDR_PORT_DIR, 8'h3F);
    $display("port and output pin test done");
    for (int i = 0; i < 4; i++)
    begin
      vin <= 8'($urandom());
      apb(1'b1, adc_pkg::ADDR_PIN_CONFIG, i[0] ? 8'h00 : 8'h06);
      conv({csv[i], 3'(i + 1), 3'h1}, hv[i], sar(vin), i == 1);
    end
    apb(1'b1, adc_pkg::ADDR_CONV_CONTROL, 8'h49);
    repeat (16) @(posedge pclk);
    apb(1'b1, adc_pkg::ADDR_CONV_CONTROL, 8'h4D);
    apb(1'b1, adc_pkg::ADDR_CONV_CONTROL, 8'h49);
    rdc(adc_pkg::ADDR_CONV_CONTROL, 32'h49);
    repeat (80) @(posedge pclk);
    rdc(adc_pkg::ADDR_PERIPH_FLAGS, 32'h0);
    rdc(adc_pkg::ADDR_RESULT, {24'h0, sar(vin)});
    apb(1'b1, adc_pkg::ADDR_CONV_CONTROL, 8'h48);
    pulse();
    rdc(adc_pkg::ADDR_CONV_CONTROL, 32'h48);
    chk({28'h0, chan, on_bit}, 32'h2);
    $display("conversion and trigger test done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(adc_pkg::ADDR_RESULT, {24'h0, sar(vin)});
    apb(1'b1, adc_pkg::ADDR_RESULT, ~sar(vin));
    rdc(adc_pkg::ADDR_RESULT, {24'h0, sar(vin)});
    $display("result retention test done");
    finish_test();
  end
endmodule
